// >>> rtl/cycle_sel_pkg.sv
// constants and types shared by both ends of the bus-cycle selector
// ==========================================================================
// Overview of operation
// - route each bus cycle local or system
// - decide for memory, io and acknowledge
// - memory inside system windows goes system
// - controller and arbiter latch the selection
// - all controllers local: acknowledge goes local
// - all terminal controllers system: acknowledge system
// - mixed: decode three cascade lines
// - two acknowledge cycles, vector in second
// - request arbiter, then enable system transceivers
// - cascade bits drive A8, A9, A10
// - wait 565 ns plus 30 ns decode
// - at least four wait states first cycle
// - local choice ends first cycle promptly
// - system choice keeps first cycle extended
// - drive command delay as select input
// - system acknowledge ended by transfer acknowledge
// - cascade gate active in second cycle
// - cascade gate outlasts address strobe one clock
// - cascade gate only during acknowledge cycles
`default_nettype none
package cycle_sel_pkg;
  // ==========================================================================
  // timing
  localparam int CLK_PERIOD_NS = 8;
  localparam int CASCADE_VALID_NS = 565;
  localparam int DECODE_DELAY_NS = 30;
  localparam int SELECT_VALID_NS = CASCADE_VALID_NS + DECODE_DELAY_NS;
  // least time: round up
  localparam int SELECT_VALID_CYCLES = (SELECT_VALID_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int MIN_WAIT_STATES = 4;
  localparam int WAIT_CNT_W = 8;
  // ==========================================================================
  // address layout
  localparam int ADDR_W = 24;
  localparam int CASCADE_LSB = 8;
  localparam int CASCADE_W = 3;
  // ==========================================================================
  // operation kinds and interrupt-controller placement
  typedef enum logic [1:0] {OP_MEM, OP_IO, OP_ACK} op_kind_e;
  typedef enum logic [1:0] {PIC_ALL_LOCAL, PIC_ALL_SYSTEM, PIC_MIXED} pic_place_e;
  localparam logic [ADDR_W-1:0] WIN0_BASE = 24'h80_0000;
  localparam logic [ADDR_W-1:0] WIN0_LIMIT = 24'hBF_FFFF;
  localparam logic [ADDR_W-1:0] WIN1_BASE = 24'hE0_0000;
  localparam logic [ADDR_W-1:0] WIN1_LIMIT = 24'hEF_FFFF;
  localparam logic [7:0] SYS_SLAVE_MAP = 8'hF0;
  localparam logic [15:0] IO_SYS_BASE = 16'h8000;
endpackage
`default_nettype wire

// >>> rtl/cycle_sel_if.sv
// link between the selector and the controller/arbiter side
`default_nettype none
interface cycle_sel_if;
  import cycle_sel_pkg::*;
  logic command_enable_latched;
  logic command_delay;
  logic system_or_resident_select;
  logic system_request;
  logic xcvr_enable;
  logic local_ready;
  logic [CASCADE_W-1:0] cascade_o;
  logic cascade_oe_n;
  logic master_cascade_gate;
  logic ack_cycle_start;
  logic ack_second;
  logic cycle_done;
  logic xack;
  logic bus_granted;
  modport selector (
    output command_enable_latched, command_delay, system_or_resident_select,
    output system_request, xcvr_enable, local_ready, cascade_o, cascade_oe_n,
    input master_cascade_gate, ack_cycle_start, ack_second, cycle_done, xack,
    input bus_granted
  );
  modport controller (
    input command_enable_latched, command_delay, system_or_resident_select,
    input system_request, xcvr_enable, local_ready, cascade_o, cascade_oe_n,
    output master_cascade_gate, ack_cycle_start, ack_second, cycle_done, xack,
    output bus_granted
  );
endinterface
`default_nettype wire

// >>> rtl/cycle_selector.sv
// device end: decodes each cycle and sequences acknowledge onto local or system bus
`default_nettype none
module cycle_selector
  import cycle_sel_pkg::*;
(
  // clock and reset
  input wire logic CLK,
  input wire logic RST_N,
  // processor side
  input wire logic CYCLE_START,
  input wire op_kind_e OP_KIND,
  input wire logic [ADDR_W-1:0] ADDR,
  input wire pic_place_e PIC_PLACE,
  input wire logic [CASCADE_W-1:0] CASCADE_IN,
  output logic SYSTEM_SELECTED,
  // controller and arbiter side
  cycle_sel_if.selector link
);
  // ==========================================================================
  // decoding
  function automatic logic mem_is_system(input logic [ADDR_W-1:0] a);
    mem_is_system = (a >= WIN0_BASE && a <= WIN0_LIMIT) ||
                    (a >= WIN1_BASE && a <= WIN1_LIMIT);
  endfunction

  function automatic logic cascade_is_system(input logic [CASCADE_W-1:0] c);
    cascade_is_system = SYS_SLAVE_MAP[c];
  endfunction

  function automatic logic io_is_system(input logic [ADDR_W-1:0] a);
    io_is_system = (a[$bits(IO_SYS_BASE)-1:0] >= IO_SYS_BASE);
  endfunction

  // inputs passed as arguments: an assign only wakes on its own operands
  function automatic logic mem_or_io_sel(input logic start, input op_kind_e k,
                                         input logic [ADDR_W-1:0] a);
    mem_or_io_sel = start && ((k == OP_MEM) ? mem_is_system(a) :
                    (k == OP_IO) && io_is_system(a));
  endfunction

  typedef enum {IDLE, ACK_WAIT, ACK_ARB, ACK_SYS, ACK_LOCAL_END, ACK_SECOND} st_e;
  st_e state, next_state;
  logic sel_sys, next_sel_sys;
  logic [WAIT_CNT_W-1:0] wait_cnt, next_wait_cnt;
  logic [CASCADE_W-1:0] cas_s1, cas_s2, cas_s3, cas;
  logic [CASCADE_W-1:0] next_cas;
  logic xack_s1, xack_s2, xack_s3, xack_ok;

  // ==========================================================================
  // pin synchronisers: change counts once stages two and three agree
  always_ff @(posedge CLK) begin
    cas_s1 <= CASCADE_IN;
    cas_s2 <= cas_s1;
    cas_s3 <= cas_s2;
    xack_s1 <= link.xack;
    xack_s2 <= xack_s1;
    xack_s3 <= xack_s2;
    if (!RST_N) begin
      cas <= '0;
      xack_ok <= 1'b0;
    end else begin
      cas <= next_cas;
      if (xack_s2 == xack_s3) begin
        xack_ok <= xack_s3;
      end
    end
  end
  assign next_cas = (cas_s2 == cas_s3) ? cas_s3 : cas;

  // ==========================================================================
  // cycle sequencer
  always_comb begin
    next_state = state;
    next_sel_sys = sel_sys;
    next_wait_cnt = wait_cnt;
    unique case (state)
      IDLE: begin
        if (CYCLE_START) begin
          unique case (OP_KIND)
            OP_MEM: next_sel_sys = mem_is_system(ADDR);
            OP_IO: next_sel_sys = io_is_system(ADDR);
            default: begin
              next_sel_sys = (PIC_PLACE == PIC_ALL_SYSTEM);
              next_wait_cnt = '0;
              next_state = ACK_WAIT;
            end
          endcase
        end
      end
      ACK_WAIT: begin
        // select is unsure until cascade settles plus decode delay
        next_wait_cnt = wait_cnt + 1'b1;
        if (wait_cnt >= WAIT_CNT_W'(SELECT_VALID_CYCLES - 1)) begin
          if (PIC_PLACE == PIC_MIXED) begin
            next_sel_sys = cascade_is_system(cas);
            next_state = cascade_is_system(cas) ? ACK_ARB : ACK_LOCAL_END;
          end else begin
            next_state = sel_sys ? ACK_ARB : ACK_LOCAL_END;
          end
        end
      end
      ACK_ARB: if (link.bus_granted) next_state = ACK_SYS;
      ACK_SYS: if (xack_ok) next_state = ACK_SECOND;
      ACK_LOCAL_END: next_state = ACK_SECOND;
      ACK_SECOND: if (link.cycle_done) next_state = IDLE;
      default: next_state = IDLE;
    endcase
  end

  always_ff @(posedge CLK) begin
    if (!RST_N) begin
      state <= IDLE;
      sel_sys <= 1'b0;
      wait_cnt <= '0;
    end else begin
      state <= next_state;
      sel_sys <= next_sel_sys;
      wait_cnt <= next_wait_cnt;
    end
  end

  // ==========================================================================
  // outputs; controller and arbiter latch the select themselves
  logic in_ack;
  logic sel_now;
  assign in_ack = (state != IDLE);
  assign sel_now = mem_or_io_sel(CYCLE_START, OP_KIND, ADDR);
  assign SYSTEM_SELECTED = sel_sys;
  assign link.system_or_resident_select = in_ack ? (state == ACK_ARB || state == ACK_SYS ||
                                          (state == ACK_SECOND && sel_sys))
                                        : sel_now;
  // command delay stays asserted through the cascade wait and, for a system choice, until the bus is granted
  assign link.command_delay = (state == ACK_WAIT) || (state == ACK_ARB);
  assign link.command_enable_latched = in_ack ? 1'b1 : ~sel_now;
  assign link.system_request = (state == ACK_ARB) || (state == ACK_SYS) ||
                               (state == ACK_SECOND && sel_sys);
  assign link.xcvr_enable = (state == ACK_SYS) || (state == ACK_SECOND && sel_sys);
  assign link.local_ready = (state == ACK_LOCAL_END) ||
                            (state == ACK_SECOND && !sel_sys);
  assign link.cascade_o = cas;
  // gate alone qualifies the drivers: it is only active on acknowledge
  assign link.cascade_oe_n = ~link.master_cascade_gate;
endmodule
`default_nettype wire

// >>> rtl/cycle_ctrl_end.sv
// far end: bus controller and arbiter behaviour toward the selector
`default_nettype none
module cycle_ctrl_end
  import cycle_sel_pkg::*;
(
  // clock and reset
  input wire logic CLK,
  input wire logic RST_N,
  // user side
  input wire logic ACK_START,
  input wire logic ACK_SECOND,
  input wire logic ADDR_STROBE,
  input wire logic GRANT,
  input wire logic XACK_IN,
  input wire logic DONE,
  output logic SEL_SYSTEM,
  output logic DELAYED,
  output logic READY,
  output logic [CASCADE_W-1:0] CASCADE_ADDR,
  output logic CASCADE_VALID,
  // selector side
  cycle_sel_if.controller link
);
  logic strobe_d, next_strobe_d;
  logic sel, next_sel;
  always_comb begin
    next_strobe_d = ADDR_STROBE;
    next_sel = sel;
    if (link.command_enable_latched && !link.command_delay) begin
      next_sel = link.system_or_resident_select;
    end
  end
  always_ff @(posedge CLK) begin
    if (!RST_N) begin
      strobe_d <= 1'b0;
      sel <= 1'b0;
    end else begin
      strobe_d <= next_strobe_d;
      sel <= next_sel;
    end
  end
  // gate holds one clock past strobe, only in second acknowledge
  assign link.master_cascade_gate = ACK_SECOND && (ADDR_STROBE || strobe_d);
  assign link.ack_cycle_start = ACK_START;
  assign link.ack_second = ACK_SECOND;
  assign link.cycle_done = DONE;
  assign link.xack = XACK_IN;
  assign link.bus_granted = GRANT && link.system_request;
  assign SEL_SYSTEM = sel;
  assign DELAYED = link.command_delay;
  assign READY = link.local_ready;
  assign CASCADE_ADDR = link.cascade_o;
  assign CASCADE_VALID = ~link.cascade_oe_n;
endmodule
`default_nettype wire

// >>> bench/cycle_sel_chk.sv
// concurrent checks on the selector link
`default_nettype none
module cycle_sel_chk
  import cycle_sel_pkg::*;
(
  // clock and reset
  input wire logic CLK,
  input wire logic RST_N,
  // link signals
  input wire logic command_delay,
  input wire logic system_or_resident_select,
  input wire logic system_request,
  input wire logic xcvr_enable,
  input wire logic local_ready,
  input wire logic cascade_oe_n,
  input wire logic master_cascade_gate,
  input wire logic ack_second,
  input wire logic xack,
  input wire logic bus_granted
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking @(posedge CLK);
  endclocking
  default disable iff (!RST_N);
  // ========
  // wait counter
  logic decide;
  logic [7:0] wait_cnt;
  logic [7:0] next_wait_cnt;
  assign decide = local_ready || system_request;
  // saturates so a long arbitration wait cannot wrap it
  always_comb next_wait_cnt = !command_delay ? 8'h00 : wait_cnt + {7'h00, wait_cnt != 8'hFF};
  always_ff @(posedge CLK) wait_cnt <= !RST_N ? 8'h00 : next_wait_cnt;
  // ========
  // assertions
  gate_oe_a: assert property (cascade_oe_n == !master_cascade_gate)
    else $error("cascade drive enable does not follow gate");
  min_wait_a: assert property ($rose(command_delay) |-> !decide [*8])
    else $error("acknowledge decided before wait states");
  decide_win_a: assert property ($rose(command_delay) |-> ##[70:100] decide)
    else $error("acknowledge decision late");
  wait_cnt_a: assert property ($rose(decide) && $past(command_delay) |->
    wait_cnt >= 8'(SELECT_VALID_CYCLES - 1))
    else $error("acknowledge decision before cascade valid");
  ready_excl_a: assert property (!(local_ready && (xcvr_enable || system_request)))
    else $error("local ready while system bus in use");
  xcvr_grant_a: assert property ($rose(xcvr_enable) |-> $past(system_request && bus_granted))
    else $error("transceivers enabled without grant");
  xack_end_a: assert property ($fell(xcvr_enable) |-> $past(xack, 2))
    else $error("system acknowledge ended without transfer acknowledge");
  hold_sel_a: assert property (ack_second && $past(ack_second) |->
    $stable(system_or_resident_select))
    else $error("bus choice changed in second acknowledge");
  cover property ($rose(system_request));
  cover property ($rose(local_ready) && $past(command_delay));
  cover property ($fell(xcvr_enable));
endmodule
`default_nettype wire

// >>> bench/system_bus_cycle_selector_tb.sv
// testbench for the selector and controller ends joined by their link
`default_nettype none
module system_bus_cycle_selector_tb
  import cycle_sel_pkg::*;
();
  timeunit 1ns;
  timeprecision 1ns;
  logic CLK = 0, RST_N = 0, start = 0, ack_start = 0, ack_2nd = 0;
  logic strobe = 0, grant = 0, xack_in = 0, done = 0, sys_sel;
  logic ce_sel, ce_delayed, ce_ready, ce_valid;
  logic [CASCADE_W-1:0] ce_cas;
  op_kind_e kind = OP_MEM;
  pic_place_e place = PIC_ALL_LOCAL;
  logic [ADDR_W-1:0] addr = '0;
  logic [CASCADE_W-1:0] cas = '0;
  logic [ADDR_W-1:0] bnd [4] = '{WIN0_BASE - 24'h1, WIN0_LIMIT, WIN1_BASE, WIN1_LIMIT + 24'h1};
  int n_errors = 0, cmp_count = 0, seed = 60;
  always #4 CLK = ~CLK;
  cycle_sel_if lk();
  cycle_selector i_cycle_selector(.CLK(CLK), .RST_N(RST_N), .CYCLE_START(start),
    .OP_KIND(kind), .ADDR(addr), .PIC_PLACE(place), .CASCADE_IN(cas),
    .SYSTEM_SELECTED(sys_sel), .link(lk));
  cycle_ctrl_end i_cycle_ctrl_end(.CLK(CLK), .RST_N(RST_N), .ACK_START(ack_start),
    .ACK_SECOND(ack_2nd), .ADDR_STROBE(strobe), .GRANT(grant), .XACK_IN(xack_in),
    .DONE(done), .SEL_SYSTEM(ce_sel), .DELAYED(ce_delayed), .READY(ce_ready),
    .CASCADE_ADDR(ce_cas), .CASCADE_VALID(ce_valid),
    .link(lk));
  cycle_sel_chk i_chk(.CLK(CLK), .RST_N(RST_N), .command_delay(lk.command_delay),
    .system_or_resident_select(lk.system_or_resident_select),
    .system_request(lk.system_request), .xcvr_enable(lk.xcvr_enable),
    .local_ready(lk.local_ready), .cascade_oe_n(lk.cascade_oe_n),
    .master_cascade_gate(lk.master_cascade_gate), .ack_second(lk.ack_second),
    .xack(lk.xack), .bus_granted(lk.bus_granted));
  // ========
  // reference model and helpers
  function automatic logic exp_sys(op_kind_e k, logic [23:0] a, int p, int c);
    if (k == OP_MEM)
      return (a >= WIN0_BASE && a <= WIN0_LIMIT) || (a >= WIN1_BASE && a <= WIN1_LIMIT);
    if (k == OP_IO)
      return a[15:0] >= IO_SYS_BASE;
    return p == 1 || (p == 2 && SYS_SLAVE_MAP[c]);
  endfunction
  task automatic chk(string s, logic [23:0] e, logic [23:0] g);
    cmp_count++;
    if (g !== e) begin
      n_errors++;
      $display("[FAIL] %s expected %0h seen %0h", s, e, g);
    end
  endtask
  task automatic end_of_test();
    $display("compares %0d mismatches %0d", cmp_count, n_errors);
    if (n_errors == 0 && cmp_count > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask
  task automatic ack(int p, int c);
    logic e;
    int n;
    e = exp_sys(OP_ACK, '0, p, c);
    n = 0;
    @(posedge CLK);
    start <= 1;
    ack_start <= 1;
    kind <= OP_ACK;
    place <= pic_place_e'(p);
    cas <= CASCADE_W'(c);
    @(posedge CLK);
    start <= 0;
    ack_start <= 0;
    do begin
      @(negedge CLK);
      n++;
    end while (!(lk.local_ready || lk.system_request) && n < 200);
    chk("wait", 1, 24'(n >= SELECT_VALID_CYCLES - 2 && n < 100));
    chk("bus", 24'(e), 24'(lk.system_request));
    chk("cascade", 24'(c), 24'(lk.cascade_o));
    chk("delayed", 24'(e), 24'(ce_delayed));
    chk("ready", 24'(!e), 24'(ce_ready));
    if (e) begin
      @(posedge CLK);
      grant <= 1;
      n = 0;
      do begin
        @(negedge CLK);
        n++;
      end while (!lk.xcvr_enable && n < 20);
      chk("xcvr", 1, 24'(lk.xcvr_enable));
      @(posedge CLK);
      xack_in <= 1;
    end
    // room for the three-stage acknowledge synchroniser
    repeat (8) @(posedge CLK);
    ack_2nd <= 1;
    strobe <= 1;
    @(posedge CLK);
    strobe <= 0;
    @(negedge CLK);
    chk("gate", 0, 24'(lk.cascade_oe_n));
    chk("held", 24'(e), 24'(sys_sel));
    chk("cascade valid", 1, 24'(ce_valid));
    chk("cascade addr", 24'(c), 24'(ce_cas));
    chk("controller select", 24'(e), 24'(ce_sel));
    @(posedge CLK);
    done <= 1;
    @(posedge CLK);
    done <= 0;
    ack_2nd <= 0;
    grant <= 0;
    xack_in <= 0;
    repeat (4) @(posedge CLK);
  endtask
  // ========
  // tests
  initial begin
    logic [31:0] r;
    repeat (3) @(posedge CLK);
    RST_N <= 1;
    for (int i = 0; i < 40; i++) begin
      repeat (2) @(posedge CLK);
      r = $random(seed);
      start <= 1;
      kind <= (i > 3 && i[0]) ? OP_IO : OP_MEM;
      addr <= i < 4 ? bnd[i] : (i[0] ? {8'h00, r[15:0]} : r[23:0]);
      @(negedge CLK);
      chk("select", 24'(exp_sys(kind, addr, 0, 0)), 24'(lk.system_or_resident_select));
      @(posedge CLK);
      start <= 0;
      @(negedge CLK);
      chk("latched", 24'(exp_sys(kind, addr, 0, 0)), 24'(sys_sel));
    end
    $display("decode test done");
    for (int p = 0; p < 3; p++)
      for (int c = 0; c < 8; c++)
        if (p == 2 || c == 4 * p + 1)
          ack(p, c);
    $display("acknowledge test done");
    end_of_test();
  end
  initial begin
    #200000;
    n_errors++;
    end_of_test();
  end
endmodule
`default_nettype wire
